// ==== dil_pkg.sv ====
package dil_pkg;
	// ==================================================
	// command encodings {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP       = 4'h7;
	localparam logic [3:0] CMD_DESELECT  = 4'h8;
	localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
	localparam logic [3:0] CMD_REFRESH   = 4'h1;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
	localparam logic [3:0] CMD_WRITE     = 4'h4;
	localparam logic [3:0] CMD_READ      = 4'h5;

	// ==================================================
	// widths
	localparam int ADDR_W = 14;
	localparam int BANK_W = 3;
	localparam int NUM_BANKS = 8;
	localparam int DATA_W = 8;

	// ==================================================
	// mode register select on the two low bank lines
	localparam logic [1:0] SEL_MAIN = 2'h0;
	localparam logic [1:0] SEL_EXT1 = 2'h1;
	localparam logic [1:0] SEL_EXT2 = 2'h2;
	localparam logic [1:0] SEL_EXT3 = 2'h3;

	// ==================================================
	// field positions
	localparam int ADD_LAT_LSB = 3;
	localparam int ADD_LAT_W = 3;
	localparam int CAL_LSB = 4;
	localparam int CAL_W = 3;
	localparam int DLL_RESET_POS = 8;
	localparam int DLL_DISABLE_POS = 0;
	localparam int FAST_REFRESH_POS = 7;
	localparam int DRIVE_CAL_LSB = 7;
	localparam int DRIVE_CAL_W = 3;
	localparam int PRECHARGE_ALL_POS = 10;

	// ==================================================
	// legal ranges
	localparam logic [2:0] ADD_LAT_MAX = 3'h6;
	localparam logic [2:0] CAL_MIN = 3'h3;
	localparam logic [2:0] CAL_MAX = 3'h7;
	localparam logic [2:0] DRIVE_CAL_DEFAULT = 3'h7;

	// ==================================================
	// timing, 25 ns clock
	localparam int CLK_PERIOD_PS = 25000;
	localparam int POWERUP_NS = 200000;
	localparam int CKE_WAIT_NS = 400;
	localparam int DLL_LOCK_CYC = 200;
	localparam int ACT_TO_COL_PS = 15000;
	localparam int ACT_SAME_PS = 55000;
	localparam int ACT_DIFF_PS = 10000;
	localparam int FAW_PS = 50000;
	localparam int MODE_SET_CYC = 2;
	localparam int REFRESH_PS = 127500;
	localparam int POWERUP_CYC = (POWERUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CKE_WAIT_CYC = (CKE_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ACT_TO_COL_CYC = (ACT_TO_COL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ACT_SAME_CYC = (ACT_SAME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ACT_DIFF_CYC = (ACT_DIFF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FAW_CYC = (FAW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int REFRESH_CYC = (REFRESH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ==================================================
	// defaults chosen for the operating load
	localparam logic [2:0] OP_CAL = 3'h4;
	localparam logic [2:0] OP_ADD_LAT = 3'h1;
	localparam logic [1:0] OP_BURST = 2'h2;
	localparam int RD_PIPE = 16;
endpackage

// ==== dil_link_if.sv ====
`timescale 1ns/1ps
// command/address link between controller and memory
interface dil_link_if;
	logic                        cke;
	logic [3:0]                  cmd;
	logic [dil_pkg::BANK_W-1:0]  bank;
	logic [dil_pkg::ADDR_W-1:0]  addr;
	logic [dil_pkg::DATA_W-1:0]  wrData;
	logic                        wrValid;
	logic [dil_pkg::DATA_W-1:0]  rdData;
	logic                        rdValid;

	modport ctrl (output cke, output cmd, output bank, output addr, output wrData, output wrValid,
		input rdData, input rdValid);
	modport mem (input cke, input cmd, input bank, input addr, input wrData, input wrValid,
		output rdData, output rdValid);
endinterface

// ==== dil_mem.sv ====
`timescale 1ns/1ps
// memory device end: mode registers, latency pipes, readiness
module dil_mem
(
	input  wire logic                       clk_sys,
	input  wire logic                       rst,
	input  wire logic                       clkEn,
	dil_link_if.mem                         link,
	output logic                            ready,
	output logic [2:0]                      additiveLatency,
	output logic [2:0]                      columnAccessLatency,
	output logic                            fastRefreshSelect,
	output logic                            writeCaptured,
	output logic [dil_pkg::DATA_W-1:0]      writeCapturedData
);
	// ==================================================
	// command decode
	wire isLoad = link.cke && link.cmd == dil_pkg::CMD_LOAD_MODE;
	wire isRead = link.cke && link.cmd == dil_pkg::CMD_READ;
	wire isWrite = link.cke && link.cmd == dil_pkg::CMD_WRITE;
	wire [1:0] regSel = link.bank[1:0];
	wire [2:0] addLatField = link.addr[dil_pkg::ADD_LAT_LSB +: dil_pkg::ADD_LAT_W];
	wire [2:0] calField = link.addr[dil_pkg::CAL_LSB +: dil_pkg::CAL_W];
	// reserved encodings leave the old value in place
	wire addLatLegal = addLatField <= dil_pkg::ADD_LAT_MAX;
	wire calLegal = calField >= dil_pkg::CAL_MIN && calField <= dil_pkg::CAL_MAX;
	wire dllReset = isLoad && regSel == dil_pkg::SEL_MAIN && link.addr[dil_pkg::DLL_RESET_POS];
	wire [3:0] readLat = {1'b0, additiveLatency} + {1'b0, columnAccessLatency};
	wire [3:0] writeLat = readLat - 4'h1;

	logic [7:0] lockCnt_reg;
	logic [dil_pkg::RD_PIPE-1:0] rdPipe_reg;
	logic [dil_pkg::RD_PIPE-1:0] wrPipe_reg;
	logic [dil_pkg::DATA_W-1:0] rdCount_reg;

	// ==================================================
	// mode register loads
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			additiveLatency <= 3'h0;
			columnAccessLatency <= dil_pkg::CAL_MIN;
			fastRefreshSelect <= 1'b0;
		end
		else if (clkEn && isLoad)
		begin
			if (regSel == dil_pkg::SEL_EXT1 && addLatLegal)
				additiveLatency <= addLatField;
			if (regSel == dil_pkg::SEL_MAIN && calLegal)
				columnAccessLatency <= calField;
			if (regSel == dil_pkg::SEL_EXT2)
				fastRefreshSelect <= link.addr[dil_pkg::FAST_REFRESH_POS];
		end
	end

	// ==================================================
	// dll lock count; a new reset restarts it
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			lockCnt_reg <= 8'h0;
		else if (clkEn)
		begin
			if (dllReset)
				lockCnt_reg <= 8'(dil_pkg::DLL_LOCK_CYC);
			else if (lockCnt_reg != 8'h0)
				lockCnt_reg <= lockCnt_reg - 8'h1;
		end
	end

	// ready only after a lock count has run out
	logic armed_reg;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			armed_reg <= 1'b0;
		else if (clkEn && dllReset)
			armed_reg <= 1'b1;
	end
	assign ready = armed_reg && lockCnt_reg == 8'h0;

	// ==================================================
	// latency pipes: bit n marks data due n+1 cycles after the command
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rdPipe_reg <= '0;
			wrPipe_reg <= '0;
		end
		else if (clkEn)
		begin
			rdPipe_reg <= (rdPipe_reg >> 1) | (isRead ? (16'h1 << (readLat - 4'h1)) : 16'h0);
			wrPipe_reg <= (wrPipe_reg >> 1) | (isWrite ? (16'h1 << (writeLat - 4'h1)) : 16'h0);
		end
	end

	// ==================================================
	// data: reads return a running count, writes are captured
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			link.rdValid <= 1'b0;
			link.rdData <= '0;
			rdCount_reg <= '0;
			writeCaptured <= 1'b0;
			writeCapturedData <= '0;
		end
		else if (clkEn)
		begin
			link.rdValid <= rdPipe_reg[0];
			writeCaptured <= wrPipe_reg[0] && link.wrValid;
			if (rdPipe_reg[0])
			begin
				link.rdData <= rdCount_reg;
				rdCount_reg <= rdCount_reg + 8'h1;
			end
			if (wrPipe_reg[0] && link.wrValid)
				writeCapturedData <= link.wrData;
		end
	end
endmodule

// ==== dil_ctrl.sv ====
// Function
// - additive latency zero to six only
// - early column command delayed by additive latency
// - read data after additive plus column latency
// - write latency is read latency minus one
// - leave drive calibration at default
// - fast refresh bit set when hot
// - load extended registers idle, then wait
// - third extended register written all zeros
// - two bank lines select mode register
// - only nops during powerup, then raise enable
// - wait after enable, then precharge all
// - load ext two, three, one dll on
// - dll reset load, enable high, lock
// - precharge all then two refreshes
// - main register load, dll reset low
// - calibration bits ones, then zeros
// - ready after lock count from dll reset
// - activate before read or write
// - times rounded up to whole cycles
// - same bank activate waits precharge, interval
// - different bank activates spaced by interval
// - at most four activates per window
// - column latency three to seven
`timescale 1ns/1ps
module dil_ctrl
#(
	parameter int POWERUP_CYCLES = dil_pkg::POWERUP_CYC
)
(
	input  wire logic                       clk_sys,
	input  wire logic                       rst,
	input  wire logic                       clkEn,
	dil_link_if.ctrl                        link,
	input  wire logic                       hotCase,
	input  wire logic                       reqValid,
	output logic                            reqReady,
	input  wire logic                       reqWrite,
	input  wire logic [dil_pkg::BANK_W-1:0] reqBank,
	input  wire logic [dil_pkg::ADDR_W-1:0] reqRow,
	input  wire logic [dil_pkg::ADDR_W-1:0] reqCol,
	input  wire logic [dil_pkg::DATA_W-1:0] reqData,
	output logic                            initDone,
	output logic                            rdValid,
	output logic [dil_pkg::DATA_W-1:0]      rdData
);
	typedef enum logic [4:0] {
		ST_POWERUP = 5'h00, ST_CKE_WAIT = 5'h01, ST_PRE1 = 5'h02, ST_EXT2 = 5'h03,
		ST_EXT3 = 5'h04, ST_EXT1_DLL = 5'h05, ST_MAIN_RST = 5'h06, ST_PRE2 = 5'h07,
		ST_REF1 = 5'h08, ST_REF2 = 5'h09, ST_MAIN_OP = 5'h0A, ST_DRV_CAL_ON = 5'h0B,
		ST_DRV_CAL_OFF = 5'h0C, ST_LOCK = 5'h0D, ST_IDLE = 5'h0E, ST_COLUMN = 5'h0F,
		ST_CLOSE = 5'h10
	} dil_state_e;

	// bank count must be known before the per-bank arrays below
	localparam int NB = dil_pkg::NUM_BANKS;
	dil_state_e state_reg;
	dil_state_e state_next;
	logic [17:0] wait_reg;
	logic [7:0] lock_reg;
	logic hotMeta_reg;
	logic hotSync_reg;
	logic [NB-1:0] open_reg;
	logic [dil_pkg::ADDR_W-1:0] openRow_reg [NB];
	logic [5:0] sameBank_reg [NB];
	logic [5:0] diffBank_reg;
	logic [5:0] faw_reg [4];
	logic [1:0] fawPtr_reg;
	logic [3:0] cmd_next;
	logic [dil_pkg::ADDR_W-1:0] addr_next;
	logic [dil_pkg::BANK_W-1:0] bank_next;

	// ==================================================
	// mode register words
	wire [dil_pkg::ADDR_W-1:0] ext1Base = dil_pkg::ADDR_W'({dil_pkg::OP_ADD_LAT, 3'h0});
	wire [dil_pkg::ADDR_W-1:0] ext1DrvCal = ext1Base | dil_pkg::ADDR_W'({dil_pkg::DRIVE_CAL_DEFAULT, 7'h0});
	wire [dil_pkg::ADDR_W-1:0] mainOp = dil_pkg::ADDR_W'({dil_pkg::OP_CAL, 1'b0, 1'b0, dil_pkg::OP_BURST});
	wire [dil_pkg::ADDR_W-1:0] mainRst = dil_pkg::ADDR_W'(1) << dil_pkg::DLL_RESET_POS;
	wire [dil_pkg::ADDR_W-1:0] ext2Word = dil_pkg::ADDR_W'(hotSync_reg) << dil_pkg::FAST_REFRESH_POS;
	wire [dil_pkg::ADDR_W-1:0] preAll = dil_pkg::ADDR_W'(1) << dil_pkg::PRECHARGE_ALL_POS;
	wire waitDone = wait_reg == 18'h0;
	wire tgtOpen = open_reg[reqBank];
	wire rowHit = tgtOpen && openRow_reg[reqBank] == reqRow;
	wire actOk = !tgtOpen && sameBank_reg[reqBank] == 6'h0 && diffBank_reg == 6'h0
		&& faw_reg[fawPtr_reg] == 6'h0;
	wire doAct = state_reg == ST_IDLE && reqValid && actOk;
	wire doClose = state_reg == ST_IDLE && reqValid && tgtOpen && !rowHit && waitDone;
	wire [2:0] colDelay = 3'(dil_pkg::ACT_TO_COL_CYC) - dil_pkg::OP_ADD_LAT;

	// ==================================================
	// next state and command
	always_comb
	begin
		state_next = state_reg;
		cmd_next = dil_pkg::CMD_NOP;
		addr_next = '0;
		bank_next = '0;
		reqReady = 1'b0;
		case (state_reg)
			ST_POWERUP: if (waitDone) state_next = ST_CKE_WAIT;
			ST_CKE_WAIT: if (waitDone) state_next = ST_PRE1;
			ST_PRE1: begin cmd_next = dil_pkg::CMD_PRECHARGE; addr_next = preAll; state_next = ST_EXT2; end
			ST_EXT2: if (waitDone) begin cmd_next = dil_pkg::CMD_LOAD_MODE; bank_next = 3'(dil_pkg::SEL_EXT2);
				addr_next = ext2Word; state_next = ST_EXT3; end
			ST_EXT3: if (waitDone) begin cmd_next = dil_pkg::CMD_LOAD_MODE; bank_next = 3'(dil_pkg::SEL_EXT3);
				addr_next = '0; state_next = ST_EXT1_DLL; end
			ST_EXT1_DLL: if (waitDone) begin cmd_next = dil_pkg::CMD_LOAD_MODE; bank_next = 3'(dil_pkg::SEL_EXT1);
				addr_next = ext1Base; state_next = ST_MAIN_RST; end
			ST_MAIN_RST: if (waitDone) begin cmd_next = dil_pkg::CMD_LOAD_MODE; bank_next = 3'(dil_pkg::SEL_MAIN);
				addr_next = mainRst; state_next = ST_PRE2; end
			ST_PRE2: if (waitDone) begin cmd_next = dil_pkg::CMD_PRECHARGE; addr_next = preAll;
				state_next = ST_REF1; end
			ST_REF1: if (waitDone) begin cmd_next = dil_pkg::CMD_REFRESH; state_next = ST_REF2; end
			ST_REF2: if (waitDone) begin cmd_next = dil_pkg::CMD_REFRESH; state_next = ST_MAIN_OP; end
			ST_MAIN_OP: if (waitDone) begin cmd_next = dil_pkg::CMD_LOAD_MODE; bank_next = 3'(dil_pkg::SEL_MAIN);
				addr_next = mainOp; state_next = ST_DRV_CAL_ON; end
			ST_DRV_CAL_ON: if (waitDone) begin cmd_next = dil_pkg::CMD_LOAD_MODE; bank_next = 3'(dil_pkg::SEL_EXT1);
				addr_next = ext1DrvCal; state_next = ST_DRV_CAL_OFF; end
			ST_DRV_CAL_OFF: if (waitDone) begin cmd_next = dil_pkg::CMD_LOAD_MODE; bank_next = 3'(dil_pkg::SEL_EXT1);
				addr_next = ext1Base; state_next = ST_LOCK; end
			ST_LOCK: if (lock_reg == 8'h0 && waitDone) state_next = ST_IDLE;
			ST_IDLE:
				if (reqValid && rowHit && waitDone) state_next = ST_COLUMN;
				else if (doClose) begin cmd_next = dil_pkg::CMD_PRECHARGE; bank_next = reqBank;
					state_next = ST_CLOSE; end
				else if (doAct) begin cmd_next = dil_pkg::CMD_ACTIVATE; bank_next = reqBank;
					addr_next = reqRow; end
			ST_COLUMN: begin cmd_next = reqWrite ? dil_pkg::CMD_WRITE : dil_pkg::CMD_READ; bank_next = reqBank;
				addr_next = reqCol; reqReady = 1'b1; state_next = ST_IDLE; end
			ST_CLOSE: state_next = ST_IDLE;
			default: state_next = ST_POWERUP;
		endcase
	end

	// ==================================================
	// wait counter reloaded on each command issued and when the clock enable rises
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_reg <= ST_POWERUP;
			wait_reg <= 18'(POWERUP_CYCLES);
			link.cke <= 1'b0;
		end
		else if (clkEn)
		begin
			state_reg <= state_next;
			if (state_reg == ST_POWERUP && waitDone)
			begin
				link.cke <= 1'b1;
				wait_reg <= 18'(dil_pkg::CKE_WAIT_CYC);
			end
			else if (cmd_next == dil_pkg::CMD_REFRESH)
				wait_reg <= 18'(dil_pkg::REFRESH_CYC);
			else if (cmd_next == dil_pkg::CMD_ACTIVATE)
				wait_reg <= 18'(colDelay);
			else if (cmd_next != dil_pkg::CMD_NOP)
				wait_reg <= 18'(dil_pkg::MODE_SET_CYC);
			else if (!waitDone)
				wait_reg <= wait_reg - 18'h1;
		end
	end

	// ==================================================
	// link outputs, lock count, hot input synchroniser
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			link.cmd <= dil_pkg::CMD_NOP;
			link.addr <= '0;
			link.bank <= '0;
			lock_reg <= 8'h0;
			hotMeta_reg <= 1'b0;
			hotSync_reg <= 1'b0;
		end
		else if (clkEn)
		begin
			link.cmd <= cmd_next;
			link.addr <= addr_next;
			link.bank <= bank_next;
			hotMeta_reg <= hotCase;
			hotSync_reg <= hotMeta_reg;
			if (state_reg == ST_MAIN_RST && cmd_next == dil_pkg::CMD_LOAD_MODE)
				lock_reg <= 8'(dil_pkg::DLL_LOCK_CYC);
			else if (lock_reg != 8'h0)
				lock_reg <= lock_reg - 8'h1;
		end
	end

	// ==================================================
	// per-bank open rows and activate spacing counters
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			open_reg <= '0;
			diffBank_reg <= 6'h0;
			fawPtr_reg <= 2'h0;
			for (int i = 0; i < NB; i++)
			begin
				openRow_reg[i] <= '0;
				sameBank_reg[i] <= 6'h0;
			end
			for (int j = 0; j < 4; j++)
				faw_reg[j] <= 6'h0;
		end
		else if (clkEn)
		begin
			for (int i = 0; i < NB; i++)
				if (sameBank_reg[i] != 6'h0) sameBank_reg[i] <= sameBank_reg[i] - 6'h1;
			for (int j = 0; j < 4; j++)
				if (faw_reg[j] != 6'h0) faw_reg[j] <= faw_reg[j] - 6'h1;
			if (diffBank_reg != 6'h0) diffBank_reg <= diffBank_reg - 6'h1;
			if (doClose)
				open_reg[reqBank] <= 1'b0;
			else if (doAct && state_next == ST_IDLE && cmd_next == dil_pkg::CMD_ACTIVATE)
			begin
				open_reg[reqBank] <= 1'b1;
				openRow_reg[reqBank] <= reqRow;
				sameBank_reg[reqBank] <= 6'(dil_pkg::ACT_SAME_CYC - 1);
				diffBank_reg <= 6'(dil_pkg::ACT_DIFF_CYC - 1);
				faw_reg[fawPtr_reg] <= 6'(dil_pkg::FAW_CYC - 1);
				fawPtr_reg <= fawPtr_reg + 2'h1;
			end
		end
	end

	// ==================================================
	// write data at write latency, read data returned to user
	logic [dil_pkg::RD_PIPE-1:0] wrPipe_reg;
	logic [dil_pkg::DATA_W-1:0] wrHold_reg;
	wire issueWr = state_reg == ST_COLUMN && reqWrite;
	localparam int WR_LAT = 32'(dil_pkg::OP_ADD_LAT) + 32'(dil_pkg::OP_CAL) - 1;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			wrPipe_reg <= '0;
			wrHold_reg <= '0;
			link.wrValid <= 1'b0;
			link.wrData <= '0;
			rdValid <= 1'b0;
			rdData <= '0;
			initDone <= 1'b0;
		end
		else if (clkEn)
		begin
			wrPipe_reg <= (wrPipe_reg >> 1) | (issueWr ? 16'(16'h1 << (WR_LAT - 1)) : 16'h0);
			if (issueWr) wrHold_reg <= reqData;
			link.wrValid <= wrPipe_reg[0];
			link.wrData <= wrPipe_reg[0] ? wrHold_reg : '0;
			rdValid <= link.rdValid;
			rdData <= link.rdData;
			initDone <= state_reg == ST_IDLE || state_reg == ST_COLUMN || state_reg == ST_CLOSE;
		end
	end
endmodule

// ==== dil_assertions.sv ====
`timescale 1ns/1ps
// ==================================================
// link protocol checker, watches the command wires between both ends
module dil_assertions
(
	input  wire logic                       clk_sys,
	input  wire logic                       rst,
	input  wire logic                       cke,
	input  wire logic [3:0]                 cmd,
	input  wire logic [dil_pkg::BANK_W-1:0] bank,
	input  wire logic [dil_pkg::ADDR_W-1:0] addr,
	input  wire logic                       wrValid,
	input  wire logic                       rdValid
);
	localparam int READ_LAT_CYC = dil_pkg::OP_ADD_LAT + dil_pkg::OP_CAL;
	localparam int WRITE_LAT_CYC = READ_LAT_CYC - 1;
	// read data leaves a register at the latency edge, so it is sampled one edge later
	localparam int READ_SEEN_CYC = READ_LAT_CYC + 1;

	logic [dil_pkg::NUM_BANKS-1:0] openReg;
	logic [dil_pkg::NUM_BANKS-1:0] openNext;

	// ==================================================
	// decode
	wire isLoad = (cmd == dil_pkg::CMD_LOAD_MODE);
	wire isCol  = (cmd == dil_pkg::CMD_READ) || (cmd == dil_pkg::CMD_WRITE);
	wire isIdle = (cmd == dil_pkg::CMD_NOP) || (cmd == dil_pkg::CMD_DESELECT);

	// open-row shadow; a single-bank precharge clears only that bank
	always_comb
	begin
		openNext = openReg;
		if (cmd == dil_pkg::CMD_PRECHARGE)
			openNext = addr[dil_pkg::PRECHARGE_ALL_POS] ? '0 : (openReg & ~(8'h01 << bank));
		if (cmd == dil_pkg::CMD_ACTIVATE)
			openNext[bank] = 1'b1;
	end

	always_ff @(posedge clk_sys)
		openReg <= rst ? '0 : openNext;

	// ==================================================
	// properties
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	AST_CKE_HOLD: assert property (cke |=> cke)
		else $error("clock enable dropped");
	AST_NOP_POWERUP: assert property (!cke |-> isIdle)
		else $error("command while clock enable low");
	AST_ADD_LAT_RANGE: assert property (isLoad && bank[1:0] == dil_pkg::SEL_EXT1 |-> addr[5:3] <= dil_pkg::ADD_LAT_MAX)
		else $error("reserved additive latency");
	AST_COL_LAT_RANGE: assert property (isLoad && bank[1:0] == dil_pkg::SEL_MAIN && !addr[8]
		|-> addr[6:4] inside {[dil_pkg::CAL_MIN:dil_pkg::CAL_MAX]})
		else $error("reserved column latency");
	AST_EXT3_ZERO: assert property (isLoad && bank[1:0] == dil_pkg::SEL_EXT3 |-> addr == '0)
		else $error("third extended register not zero");
	AST_EXT2_RESERVED: assert property (isLoad && bank[1:0] == dil_pkg::SEL_EXT2 |-> (addr & ~14'h0080) == '0)
		else $error("second extended register reserved bit set");
	AST_MODE_GAP: assert property (isLoad |=> isIdle)
		else $error("command inside mode set delay");
	AST_REFRESH_GAP: assert property (cmd == dil_pkg::CMD_REFRESH |=> isIdle [*5])
		else $error("command inside refresh time");
	AST_COL_OPEN: assert property (isCol |-> openReg[bank])
		else $error("column command to closed bank");
	AST_WRITE_LAT: assert property (cmd == dil_pkg::CMD_WRITE |-> ##WRITE_LAT_CYC wrValid)
		else $error("write data off latency");
	AST_READ_LAT: assert property (cmd == dil_pkg::CMD_READ |-> ##READ_SEEN_CYC rdValid)
		else $error("read data off latency");
endmodule

// ==== dram_init_latency_activate_tb.sv ====
`timescale 1ns/1ps
module dram_init_latency_activate_tb;
	localparam int PWR = 50;
	localparam logic [3:0] PRE = dil_pkg::CMD_PRECHARGE;
	localparam logic [3:0] LMC = dil_pkg::CMD_LOAD_MODE;
	localparam logic [3:0] REF = dil_pkg::CMD_REFRESH;
	localparam logic [43:0] EXP_CMD = {LMC, LMC, LMC, REF, REF, PRE, LMC, LMC, LMC, LMC, PRE};
	localparam logic [21:0] EXP_SEL = 22'h140078; // ext1 ext1 main x5 ext1 ext3 ext2 main

	logic        clk_sys, rst, clkEn, hotCase, reqValid, reqWrite, reqReady, initDone, rdValid;
	logic        ready, fastRefreshSelect, writeCaptured, readySeen;
	logic [2:0]  reqBank, additiveLatency, columnAccessLatency;
	logic [13:0] reqRow, reqCol;
	logic [7:0]  reqData, rdData, writeCapturedData;
	int          miscompares, n_compared, cyc, ckeCyc, dllCyc, nopCnt, n, nRd;
	int          lastAct [8];
	int          actCyc [$];
	int          seqCyc [$];
	logic [3:0]  seqCmd [$];
	logic [2:0]  seqBank [$];
	logic [13:0] seqAddr [$];
	logic [7:0]  expQ [$];

	dil_link_if link ();
	dil_ctrl #(.POWERUP_CYCLES(PWR)) u_dil_ctrl (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .link(link.ctrl),
		.hotCase(hotCase), .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqBank(reqBank),
		.reqRow(reqRow), .reqCol(reqCol), .reqData(reqData), .initDone(initDone), .rdValid(rdValid), .rdData(rdData));
	dil_mem u_dil_mem (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .link(link.mem), .ready(ready),
		.additiveLatency(additiveLatency), .columnAccessLatency(columnAccessLatency),
		.fastRefreshSelect(fastRefreshSelect), .writeCaptured(writeCaptured), .writeCapturedData(writeCapturedData));
	dil_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .cke(link.cke), .cmd(link.cmd), .bank(link.bank),
		.addr(link.addr), .wrValid(link.wrValid), .rdValid(link.rdValid));

	// ==================================================
	// helpers
	task automatic chk(input logic ok, input string what);
		n_compared++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// one request held until the edge after reqReady is seen high
	task automatic access(input logic wr, input logic [2:0] b, input logic [13:0] row, input logic [7:0] d);
		@(posedge clk_sys);
		reqValid <= 1'b1;
		reqWrite <= wr;
		reqBank <= b;
		reqRow <= row;
		reqCol <= {6'h00, d};
		reqData <= d;
		if (wr)
			expQ.push_back(d);
		n = 0;
		do @(negedge clk_sys); while (reqReady !== 1'b1 && ++n < 300);
		chk(n < 300, "request not taken");
		@(posedge clk_sys);
		reqValid <= 1'b0;
		n = 0;
		if (!wr)
			do @(negedge clk_sys); while (rdValid !== 1'b1 && ++n < 20);
		chk(n < 20, "read data missing");
		// the memory end returns a running count, so reads come back in order
		if (!wr)
		begin
			chk(rdData === 8'(nRd), "read data order");
			nRd++;
		end
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ==================================================
	// link monitor, sampled mid-cycle where every output has settled
	always @(negedge clk_sys)
	begin
		cyc++;
		if (!rst && link.cke !== 1'b1)
			nopCnt++;
		if (link.cke === 1'b1 && ckeCyc < 0)
			ckeCyc = cyc;
		if (!rst && link.cke === 1'b1 && link.cmd !== dil_pkg::CMD_NOP && link.cmd !== dil_pkg::CMD_DESELECT)
		begin
			seqCmd.push_back(link.cmd);
			seqBank.push_back(link.bank);
			seqAddr.push_back(link.addr);
			seqCyc.push_back(cyc);
		end
		if (link.cmd === LMC && link.bank[1:0] === 2'h0 && link.addr[8] === 1'b1)
			dllCyc = cyc;
		if (ready === 1'b1 && !readySeen)
		begin
			readySeen = 1'b1;
			chk(cyc - dllCyc >= dil_pkg::DLL_LOCK_CYC, "ready before lock");
		end
		if (link.cmd === dil_pkg::CMD_READ || link.cmd === dil_pkg::CMD_WRITE)
			chk(cyc - lastAct[link.bank] >= dil_pkg::ACT_TO_COL_CYC - dil_pkg::OP_ADD_LAT, "early column");
		if (link.cmd === dil_pkg::CMD_ACTIVATE)
		begin
			if (actCyc.size() > 0)
				chk(cyc - actCyc[$] >= dil_pkg::ACT_DIFF_CYC, "activate spacing");
			if (actCyc.size() > 3)
				chk(cyc - actCyc[$-3] >= dil_pkg::FAW_CYC, "four activate window");
			if (lastAct[link.bank] >= 0)
				chk(cyc - lastAct[link.bank] >= dil_pkg::ACT_SAME_CYC, "same bank spacing");
			lastAct[link.bank] = cyc;
			actCyc.push_back(cyc);
		end
		if (writeCaptured === 1'b1)
			chk(expQ.size() > 0 && writeCapturedData === expQ.pop_front(), "write data");
		// ceiling far above init plus the accesses; a hang ends in the report
		if (cyc > 20000)
		begin
			miscompares++;
			summarize();
		end
	end

	// ==================================================
	// main sequence
	initial
	begin
		{rst, clkEn, hotCase} = 3'h7;
		{reqValid, reqWrite, reqBank, reqRow, reqCol, reqData} = '0;
		{cyc, nopCnt, ckeCyc, dllCyc, readySeen} = {32'h0, 32'h0, -32'sd1, 32'h40000000, 1'b0};
		foreach (lastAct[i])
			lastAct[i] = -100;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		n = 0;
		while ((initDone !== 1'b1 || ready !== 1'b1) && n < 3000)
		begin
			@(negedge clk_sys);
			n++;
		end
		chk(n < 3000, "init not finished");
		chk(nopCnt >= PWR, "power-up wait short");
		chk(seqCmd.size() >= 11, "init command count");
		for (int i = 0; i < 11; i++)
		begin
			chk(seqCmd[i] === EXP_CMD[i*4+:4], "init order");
			if (EXP_CMD[i*4+:4] == LMC)
				chk(seqBank[i][1:0] === EXP_SEL[i*2+:2], "mode select");
		end
		chk(seqAddr[0][10] === 1'b1 && seqCyc[0] - ckeCyc >= dil_pkg::CKE_WAIT_CYC, "first precharge");
		chk(seqAddr[1] === 14'h0080 && seqAddr[2] === 14'h0000, "ext2 ext3 values");
		chk(seqAddr[3][0] === 1'b0, "dll enable");
		chk(seqAddr[4][8] === 1'b1 && seqAddr[8][8] === 1'b0, "dll reset bit");
		chk(seqAddr[9][9:7] === 3'h7 && seqAddr[10][9:7] === 3'h0, "drive calibration");
		chk(seqAddr[10][5:3] === dil_pkg::OP_ADD_LAT && seqAddr[8][6:4] === dil_pkg::OP_CAL, "latency fields");
		chk(additiveLatency === dil_pkg::OP_ADD_LAT && columnAccessLatency === dil_pkg::OP_CAL, "latencies");
		chk(fastRefreshSelect === 1'b1, "fast refresh");
		// a request pending while the clock enable is low must not reach the link
		@(posedge clk_sys);
		clkEn <= 1'b0;
		reqValid <= 1'b1;
		reqBank <= 3'h7;
		n = seqCmd.size();
		repeat (6) @(posedge clk_sys);
		chk(seqCmd.size() == n && reqReady === 1'b0, "clock enable freeze");
		clkEn <= 1'b1;
		reqValid <= 1'b0;
		// five banks opened in turn, then a row miss, a hit and a read elsewhere
		for (int i = 0; i < 5; i++)
			access(1'b1, 3'(i), 14'(i + 1), 8'h10 + 8'(i));
		access(1'b1, 3'h0, 14'h0009, 8'hC3);
		access(1'b0, 3'h0, 14'h0009, 8'h00);
		access(1'b0, 3'h3, 14'h0004, 8'h00);
		repeat (20) @(negedge clk_sys);
		chk(expQ.size() == 0, "writes lost");
		summarize();
	end
endmodule
